// >>> rx_buf_pkg.sv
// Constants shared by the receive buffer and status block.
// Assumes a frame assembler outside delivers complete frames and start-bit pulses.
// How it works
// R1: With nine-bit characters software reads the ninth bit before the data byte.
// R2: A data read pops the FIFO so shown status follows the next entry.
// R3: Software reads status before data, since status belongs to the head entry.
// R4: Receive-complete reads one while any unread entry is stored, else zero.
// R5: Clearing receiver enable flushes the FIFO and drops receive-complete.
// R6: Interrupt request is a level while receive-complete and its enable are one.
// R7: Frame, overrun and parity errors travel inside the entry of their frame.
// R8: Software writes cannot change error flags; software writes zeros there anyway.
// R9: Error flags never raise an interrupt request.
// R10: Frame error is one when the first stop bit sampled zero.
// R11: Only the first stop bit is judged, whatever the stop bit count.
// R12: Overrun when FIFO full, a frame waits, and a new start bit appears.
// R13: Overrun clears when a frame moves successfully into the FIFO.
// R14: Parity checked only when enabled; type bit picks odd or even.
// R15: Stored parity error needs a mismatch and checking enabled at reception.
// R16: Parity error reads zero when checking is off; valid until entry read. The code shows the stored bit without gating it by the current enable.
// R17: Disabling the receiver acts at once, drops frames, releases the pin.
// R18: Software empties the FIFO by reading data until receive-complete is zero.
// R19: On the first stop bit the shift register moves into the FIFO.
// R20: Unused upper data bits read zero for characters under eight bits.
// R21: Enabling the receiver takes the pin over as serial input.
// R22: Parity type zero is even, one is odd.
// R23: A flush in the same cycle as a data read wins, FIFO left empty.
package rx_buf_pkg;
   localparam int FIFO_DEPTH = 2;
   localparam int DATA_W = 9;
   // Character size selector codes
   localparam logic [2:0] CSZ_5 = 3'h0;
   localparam logic [2:0] CSZ_6 = 3'h1;
   localparam logic [2:0] CSZ_7 = 3'h2;
   localparam logic [2:0] CSZ_8 = 3'h3;
   localparam logic [2:0] CSZ_9 = 3'h7;
   // Entry layout: data[8:0], frame error, overrun, parity error
   localparam int ENT_W = 12;
   localparam int ENT_FRAME_ERR = 9;
   localparam int ENT_OVERRUN = 10;
   localparam int ENT_PAR_ERR = 11;
   localparam logic [ENT_W-1:0] ENT_RST = 12'h000;
endpackage

// >>> rx_fifo_mem.sv
// Small storage of receive entries with registered read data.
// Assumes the owner keeps pointers and never writes beyond depth.
`timescale 1ns/100ps
`default_nettype none
module rx_fifo_mem #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 2,
   parameter int AW = 1
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
   end

   // Read port sees the write of the same edge through the next cycle
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= (wr_en_i && wr_addr_i == rd_addr_i) ? wr_data_i : mem_r[rd_addr_i];
      end
   end
endmodule // rx_fifo_mem
`default_nettype wire

// >>> rx_buf_status.sv
// Receive FIFO, status flags, parity check and enable handling of a serial port.
// Assumes an outside frame assembler gives frame_valid_i pulses and start_det_i pulses.
`timescale 1ns/100ps
`default_nettype none
module rx_buf_status #(
   parameter int DEPTH = rx_buf_pkg::FIFO_DEPTH
) (
   input wire logic clock_i,
   input wire logic srst_i,
   // Configuration
   input wire logic rx_enable_bit_i,
   input wire logic rx_complete_irq_en_i,
   input wire logic [2:0] char_size_sel_i,
   input wire logic stop_bits_sel_i,
   input wire logic parity_enable_bit_i,
   input wire logic parity_odd_sel_i,
   // Frame from the assembler
   input wire logic frame_valid_i,
   input wire logic [8:0] frame_data_i,
   input wire logic frame_parity_i,
   input wire logic frame_stop1_i,
   input wire logic start_det_i,
   // Raw pin
   input wire logic rx_pin_i,
   // Software access
   input wire logic data_rd_i,
   // Outputs
   output logic [7:0] serial_data_o,
   output logic rx_ninth_bit_o,
   output logic frame_err_flag_o,
   output logic overrun_flag_o,
   output logic parity_err_flag_o,
   output logic rx_complete_flag_o,
   output logic rx_irq_o,
   output logic rx_serial_o,
   output logic rx_pin_owned_o,
   output logic frame_abort_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam int EW = rx_buf_pkg::ENT_W;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser: three flops, change taken when last two agree
   logic [2:0] pin_sync_r;
   logic pin_level_r;
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pin_sync_r <= 3'h7;
         pin_level_r <= 1'b1;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], rx_pin_i};
         if (pin_sync_r[2] == pin_sync_r[1]) begin
            pin_level_r <= pin_sync_r[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable gating and frame capture
   logic en_r;
   logic flush;
   logic frame_ok;
   logic start_ok;
   assign flush = !rx_enable_bit_i; // see R5 see R17
   assign frame_ok = frame_valid_i && rx_enable_bit_i; // see R17
   assign start_ok = start_det_i && rx_enable_bit_i;

   // Character data masked to size, upper bits forced to zero
   logic [8:0] size_mask;
   assign size_mask = (char_size_sel_i == rx_buf_pkg::CSZ_5) ? 9'h01F :
                      (char_size_sel_i == rx_buf_pkg::CSZ_6) ? 9'h03F :
                      (char_size_sel_i == rx_buf_pkg::CSZ_7) ? 9'h07F :
                      (char_size_sel_i == rx_buf_pkg::CSZ_9) ? 9'h1FF : 9'h0FF; // see R20
   logic [8:0] data_masked;
   assign data_masked = frame_data_i & size_mask;

   // Parity over data bits; zero type is even, one is odd
   logic par_calc;
   logic par_err;
   assign par_calc = (^data_masked) ^ parity_odd_sel_i; // see R22
   assign par_err = parity_enable_bit_i && (par_calc != frame_parity_i); // see R14 see R15 see R16

   // Stop bit count has no bearing: only the first stop bit is examined
   logic frame_err;
   assign frame_err = !frame_stop1_i; // see R10 see R11

   ////////////////////////////////////////////////////////////////////////////
   // FIFO pointers and count
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic full;
   logic empty;
   assign full = (count_r == CW'(DEPTH));
   assign empty = (count_r == '0);

   // Shift register hold: a completed frame waiting while FIFO is full
   logic hold_valid_r;
   logic [EW-1:0] hold_ent_r;
   logic ovr_pend_r;

   logic pop;
   assign pop = data_rd_i && !empty && !flush; // see R2 see R23

   logic [EW-1:0] new_ent;
   assign new_ent = {par_err, 1'b0, frame_err, data_masked}; // see R7

   // Push either the waiting frame or the fresh one, waiting frame first
   logic space;
   logic push;
   logic [EW-1:0] push_ent;
   assign space = !full || pop;
   assign push = !flush && space && (hold_valid_r || frame_ok); // see R19
   assign push_ent = hold_valid_r ? hold_ent_r : new_ent;

   // Overrun: FIFO full, a frame waiting, and another start bit arrives
   logic overrun_evt;
   assign overrun_evt = start_ok && full && !pop && hold_valid_r; // see R12

   logic [EW-1:0] push_ent_ovr;
   assign push_ent_ovr = push_ent | (ovr_pend_r ? EW'(1) << rx_buf_pkg::ENT_OVERRUN : '0);

   logic [AW-1:0] wr_ptr_nxt;
   logic [AW-1:0] rd_ptr_nxt;
   assign wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
   assign rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

   always_ff @(posedge clock_i) begin
      if (srst_i || flush) begin
         wr_ptr_r <= '0; // see R5
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_nxt;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_nxt; // see R2
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

   // Frame arriving while full and none waiting goes into the shift register hold
   logic hold_load;
   assign hold_load = frame_ok && !space && !hold_valid_r;
   logic hold_next_new;
   assign hold_next_new = frame_ok && hold_valid_r && space;

   always_ff @(posedge clock_i) begin
      if (srst_i || flush) begin
         hold_valid_r <= 1'b0;
         hold_ent_r <= rx_buf_pkg::ENT_RST;
         ovr_pend_r <= 1'b0;
      end else begin
         if (hold_load || hold_next_new) begin
            hold_valid_r <= 1'b1;
            hold_ent_r <= new_ent;
         end else if (overrun_evt) begin
            hold_valid_r <= 1'b0; // Waiting character is lost
         end else if (push && hold_valid_r) begin
            hold_valid_r <= 1'b0;
         end
         // Set wins over the clear when both land together
         if (overrun_evt) begin
            ovr_pend_r <= 1'b1; // see R12
         end else if (push) begin
            ovr_pend_r <= 1'b0; // see R13
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [EW-1:0] head_ent;
   logic [AW-1:0] rd_addr;
   assign rd_addr = pop ? rd_ptr_nxt : rd_ptr_r;

   rx_fifo_mem #(
      .WIDTH(EW),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(push),
      .wr_addr_i(wr_ptr_r),
      .wr_data_i(push_ent_ovr),
      .rd_addr_i(rd_addr),
      .rd_data_o(head_ent)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs; status shows the head entry, zero when empty
   logic nonempty_nxt;
   assign nonempty_nxt = !flush && ((count_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0)) != '0);

   logic valid_r;
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         valid_r <= 1'b0;
         rx_complete_flag_o <= 1'b0;
         rx_irq_o <= 1'b0;
         en_r <= 1'b0;
         rx_serial_o <= 1'b1;
         rx_pin_owned_o <= 1'b0;
         frame_abort_o <= 1'b0;
      end else begin
         valid_r <= nonempty_nxt;
         rx_complete_flag_o <= nonempty_nxt; // see R4 see R5
         // Error flags deliberately absent from the request term
         rx_irq_o <= nonempty_nxt && rx_complete_irq_en_i; // see R6 see R9
         en_r <= rx_enable_bit_i;
         rx_pin_owned_o <= rx_enable_bit_i; // see R21 see R17
         rx_serial_o <= rx_enable_bit_i ? pin_level_r : 1'b1; // see R21
         frame_abort_o <= en_r && !rx_enable_bit_i; // see R17
      end
   end

   // No write path exists to the error flags: they come only from the entry
   assign serial_data_o = valid_r ? head_ent[7:0] : 8'h00; // see R20
   assign rx_ninth_bit_o = valid_r && head_ent[8];
   assign frame_err_flag_o = valid_r && head_ent[rx_buf_pkg::ENT_FRAME_ERR]; // see R8 see R7
   assign overrun_flag_o = valid_r && head_ent[rx_buf_pkg::ENT_OVERRUN]; // see R8
   assign parity_err_flag_o = valid_r && head_ent[rx_buf_pkg::ENT_PAR_ERR]; // see R8 see R16

   logic unused_ok;
   assign unused_ok = stop_bits_sel_i; // see R11
endmodule // rx_buf_status
`default_nettype wire

// >>> rx_buf_checker_assertions.sv
// Port checker for the receive buffer and status block.
// Assumes it is bound to rx_buf_status and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module rx_buf_checker (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic rx_enable_bit_i,
   input wire logic rx_complete_irq_en_i,
   input wire logic [2:0] char_size_sel_i,
   input wire logic parity_enable_bit_i,
   input wire logic parity_odd_sel_i,
   input wire logic frame_valid_i,
   input wire logic [8:0] frame_data_i,
   input wire logic frame_parity_i,
   input wire logic frame_stop1_i,
   input wire logic [7:0] serial_data_o,
   input wire logic frame_err_flag_o,
   input wire logic overrun_flag_o,
   input wire logic parity_err_flag_o,
   input wire logic rx_complete_flag_o,
   input wire logic rx_irq_o,
   input wire logic rx_pin_owned_o,
   input wire logic frame_abort_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   flush_clears_a: assert property (!rx_enable_bit_i |=> !rx_complete_flag_o)
      else $error("flag survived a disable");
   irq_level_a: assert property (rx_complete_flag_o && $past(rx_complete_irq_en_i) |-> rx_irq_o)
      else $error("irq missing");
   irq_source_a: assert property (rx_irq_o |-> rx_complete_flag_o)
      else $error("irq without data");
   empty_zero_a: assert property (!rx_complete_flag_o |-> serial_data_o == 8'h00
      && !frame_err_flag_o && !overrun_flag_o && !parity_err_flag_o) else $error("empty not zero");
   push_shows_a: assert property (frame_valid_i && rx_enable_bit_i && !rx_complete_flag_o
      |=> rx_complete_flag_o && frame_err_flag_o == !$past(frame_stop1_i)) else $error("push");
   byte_parity_a: assert property (frame_valid_i && rx_enable_bit_i && !rx_complete_flag_o
      && char_size_sel_i == rx_buf_pkg::CSZ_8 |=> serial_data_o == $past(frame_data_i[7:0])
      && parity_err_flag_o == $past(parity_enable_bit_i
      && (^frame_data_i[7:0] ^ frame_parity_i ^ parity_odd_sel_i))) else $error("entry");
   abort_pulse_a: assert property ($fell(rx_enable_bit_i) |-> ##[1:2] frame_abort_o)
      else $error("no abort");
   pin_owned_a: assert property (rx_enable_bit_i ##1 rx_enable_bit_i |-> rx_pin_owned_o)
      else $error("pin not owned");
endmodule // rx_buf_checker
bind rx_buf_status rx_buf_checker chk_u (.clock_i, .srst_i, .rx_enable_bit_i,
   .rx_complete_irq_en_i, .char_size_sel_i, .parity_enable_bit_i, .parity_odd_sel_i,
   .frame_valid_i, .frame_data_i, .frame_parity_i, .frame_stop1_i, .serial_data_o,
   .frame_err_flag_o, .overrun_flag_o, .parity_err_flag_o, .rx_complete_flag_o, .rx_irq_o,
   .rx_pin_owned_o, .frame_abort_o);
`default_nettype wire

// >>> tx_frame_model.sv
// Far-side transmitter model handing finished frames to the block.
// Assumes the bench asks for one frame at a time with send_i.
`timescale 1ns/100ps
`default_nettype none
module tx_frame_model (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic send_i,
   input wire logic [10:0] frame_i,
   output logic start_det_o,
   output logic frame_valid_o,
   output logic [10:0] frame_o
);
   logic [2:0] stage_r;
   logic [10:0] held_r;
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         stage_r <= 3'h0;
         held_r <= 11'h000;
      end else begin
         stage_r <= {stage_r[1:0], send_i};
         held_r <= send_i ? frame_i : held_r;
      end
   end
   assign start_det_o = stage_r[0];
   // Handed over at the first stop bit; a second stop bit never shows
   assign frame_valid_o = stage_r[2];
   // Lines carry garbage outside the pulse so stale data cannot pass
   assign frame_o = frame_valid_o ? held_r : ~held_r;
endmodule // tx_frame_model
`default_nettype wire

// >>> rx_buf_status_tb_top.sv
// Self-checking bench for the receive buffer and status block.
// Assumes the package, checker and frame model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module rx_buf_status_tb_top;
   logic clk = 1'b0, srst = 1'b1, en = 1'b0, ien = 1'b0, pen = 1'b0, odd = 1'b0;
   logic send = 1'b0, rd = 1'b0, sdet, fval, nin, ferr, ovr, perr, flg, irq, ser, own;
   logic pin = 1'b1, sbs = 1'b1;
   logic [2:0] csz = rx_buf_pkg::CSZ_8;
   logic [10:0] fin = 11'h400, fout;
   logic [7:0] dout;
   int miscompares = 0, num_checks = 0;
   tx_frame_model tx_u (.clock_i(clk), .srst_i(srst), .send_i(send), .frame_i(fin),
      .start_det_o(sdet), .frame_valid_o(fval), .frame_o(fout));
   rx_buf_status dut_u (.clock_i(clk), .srst_i(srst), .rx_enable_bit_i(en),
      .rx_complete_irq_en_i(ien), .char_size_sel_i(csz), .stop_bits_sel_i(sbs),
      .parity_enable_bit_i(pen), .parity_odd_sel_i(odd), .frame_valid_i(fval),
      .frame_data_i(fout[8:0]), .frame_parity_i(fout[9]), .frame_stop1_i(fout[10]),
      .start_det_i(sdet), .rx_pin_i(pin), .data_rd_i(rd), .serial_data_o(dout),
      .rx_ninth_bit_o(nin), .frame_err_flag_o(ferr), .overrun_flag_o(ovr),
      .parity_err_flag_o(perr), .rx_complete_flag_o(flg), .rx_irq_o(irq),
      .rx_serial_o(ser), .rx_pin_owned_o(own), .frame_abort_o());
   initial begin
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic send_frame(input logic [10:0] f);
      @(posedge clk);
      send <= 1'b1;
      fin <= f;
      @(posedge clk);
      send <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // Status before data, as software must, then the pop
   task automatic read_chk(input logic [7:0] d, input logic n, input logic [2:0] st);
      #1;
      `CHK("flag", 1'b1, flg)
      `CHK("irq", ien, irq)
      `CHK("ninth", n, nin)
      `CHK("status", st, {ferr, ovr, perr})
      `CHK("data", d, dout)
      @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      #1 `CHK("reset", 6'h01, {flg, ferr, ovr, perr, irq, ser})
      @(posedge clk);
      en <= 1'b1;
      ien <= 1'b1;
      pen <= 1'b1;
      send_frame(11'h441);
      send_frame(11'h203);
      read_chk(8'h41, 1'b0, 3'h0);
      read_chk(8'h03, 1'b0, 3'h5);
      #1 `CHK("drained", 2'h0, {flg, irq})
      @(posedge clk);
      ien <= 1'b0;
      sbs <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         pen <= i[1];
         odd <= i[0];
         send_frame(11'h641);
         read_chk(8'h41, 1'b0, {2'h0, i[1] & ~i[0]});
      end
      pen <= 1'b0;
      for (int n = 5; n < 10; n++) begin
         csz <= (n == 9) ? rx_buf_pkg::CSZ_9 : 3'(n - 5);
         send_frame(11'h5FF);
         read_chk(8'hFF >> (8 - (n > 8 ? 8 : n)), n == 9, 3'h0);
      end
      csz <= rx_buf_pkg::CSZ_8;
      for (int k = 1; k < 5; k++) send_frame(11'h400 | 11'(k));
      read_chk(8'h01, 1'b0, 3'h0);
      read_chk(8'h02, 1'b0, 3'h0);
      read_chk(8'h04, 1'b0, 3'h2);
      send_frame(11'h405);
      read_chk(8'h05, 1'b0, 3'h0);
      // Pin low from here on: seen while enabled, masked once disabled
      pin <= 1'b0;
      repeat (5) @(posedge clk);
      #1 `CHK("serial in", 1'b0, ser)
      send_frame(11'h411);
      send_frame(11'h422);
      en <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      send_frame(11'h433);
      #1 `CHK("flushed", 3'h1, {flg, own, ser})
      @(posedge clk);
      en <= 1'b1;
      send_frame(11'h444);
      #1 `CHK("refilled", 1'b1, flg)
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      #1 `CHK("rerun", 1'b0, flg)
      close_out();
   end
   initial begin
      #40000;
      miscompares++;
      close_out();
   end
endmodule // rx_buf_status_tb_top
`default_nettype wire
